/* File: logic/pif_flag_bank.sv */
// Purpose: sticky event flags with write-one-to-clear access and protection outputs
// Assumes: register port driven by same-clock serial engine; analog events asynchronous
// Notes: read data appears the cycle after a read strobe
// Notes: a restart clears every flag except the reset flag, which it sets, and wins over any event of that cycle
`default_nettype none
module pif_flag_bank #(
  parameter int SHORT_CYCLES = pif_pkg::SHORT_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire pif_pkg::pif_req_t req,
  input wire pif_pkg::pif_ev_t ev_async,
  input wire logic load_current_ready,
  output logic [7:0] rdata,
  output logic regulators_off,
  output logic general_outputs_low,
  output logic enable_refused,
  output logic defaults_reload
);
  localparam int NEV = $bits(pif_pkg::pif_ev_t);

  typedef struct packed {
    logic [NEV-1:0] sync1;
    logic [NEV-1:0] sync2;
    logic [NEV-1:0] prev;
    logic [7:0] top_flags;
    logic reset_flag;
    logic [7:0] step_flags;
    logic [7:0] lin_flags;
    logic [pif_pkg::NREG-1:0][pif_pkg::CNT_W-1:0] sc_cnt;
    logic [7:0] rdata;
    logic regulators_off;
    logic general_outputs_low;
    logic enable_refused;
    logic defaults_reload;
  } pif_state_t;

  pif_state_t st_reg;
  pif_state_t st_next;
  pif_pkg::pif_ev_t ev;
  pif_pkg::pif_ev_t ev_prev;
  logic [pif_pkg::NREG-1:0][pif_pkg::CNT_W-1:0] cnt_next;
  logic [pif_pkg::NREG-1:0] sc_set;
  logic [7:0] step_set;
  logic [7:0] lin_set;

  // Two flops per event bit; prev is an extra stage used only for edge detection
  assign ev = st_reg.sync2;
  assign ev_prev = st_reg.prev;

  genvar g;
  generate
    for (g = 0; g < pif_pkg::NREG; g++)
    begin : g_reg
      // Saturate so a long short does not wrap and re-arm
      assign cnt_next[g] = !ev.short_low[g] ? '0 :
        (st_reg.sc_cnt[g] >= pif_pkg::CNT_W'(SHORT_CYCLES)) ? st_reg.sc_cnt[g] :
        st_reg.sc_cnt[g] + 1'b1;
      assign sc_set[g] = st_reg.sc_cnt[g] >= pif_pkg::CNT_W'(SHORT_CYCLES);
    end
    for (g = 0; g < 2; g++)
    begin : g_lane
      localparam int B = g * pif_pkg::REG_STRIDE;
      assign step_set[B + pif_pkg::PG_OFS] = ev.pg_bad[g] & ~ev_prev.pg_bad[g];
      assign step_set[B + pif_pkg::SC_OFS] = sc_set[g];
      assign step_set[B + pif_pkg::ILIM_OFS] = ev.ilim[g];
      assign step_set[B + 3] = 1'b0;
      assign lin_set[B + pif_pkg::PG_OFS] = ev.pg_bad[g+2] & ~ev_prev.pg_bad[g+2];
      assign lin_set[B + pif_pkg::SC_OFS] = sc_set[g+2];
      assign lin_set[B + pif_pkg::ILIM_OFS] = ev.ilim[g+2];
      assign lin_set[B + 3] = 1'b0;
    end
  endgenerate

  always_comb
  begin
    logic [7:0] top_set;
    logic [7:0] clr;
    logic restart;
    logic [7:0] top_view;
    st_next = st_reg;
    top_set = '0;
    restart = 1'b0;
    top_view = 8'h00;
    clr = req.wr ? req.wdata : 8'h00;
    st_next.sync1 = ev_async;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;
    st_next.sc_cnt = cnt_next;
    top_set[pif_pkg::PG_DROP_BIT] = ev_prev.power_good_active & ~ev.power_good_active;
    top_set[pif_pkg::SYNC_BIT] = ev.sync_clk_present ^ ev_prev.sync_clk_present;
    top_set[pif_pkg::TSD_BIT] = ev.thermal_shutdown_live;
    top_set[pif_pkg::WARN_BIT] = ev.thermal_warning_live;
    top_set[pif_pkg::OVP_BIT] = ev.input_overvoltage_live;
    top_set[pif_pkg::MEAS_BIT] = load_current_ready;
    // Set is ORed after the clear so a coincident event survives
    st_next.top_flags = ((st_reg.top_flags &
      ~((req.wr && req.addr == pif_pkg::TOP_ADDR) ? clr : 8'h00)) | top_set)
      & ~(8'h01 << pif_pkg::LIN_SUM_BIT) & ~(8'h01 << pif_pkg::STEP_SUM_BIT);
    st_next.step_flags = ((st_reg.step_flags &
      ~((req.wr && req.addr == pif_pkg::STEP_ADDR) ? clr : 8'h00)) | step_set)
      & pif_pkg::FLAG_MASK;
    st_next.lin_flags = ((st_reg.lin_flags &
      ~((req.wr && req.addr == pif_pkg::LIN_ADDR) ? clr : 8'h00)) | lin_set)
      & pif_pkg::FLAG_MASK;
    st_next.reset_flag = st_reg.reset_flag &
      ~(req.wr && req.addr == pif_pkg::RESET_EV_ADDR && req.wdata[0]);
    // The command register stores nothing; the write itself is the restart pulse
    restart = (ev.analog_supply_under & ~ev_prev.analog_supply_under) |
      (req.wr && req.addr == pif_pkg::RESET_CMD_ADDR &&
       req.wdata[pif_pkg::SOFT_RESET_BIT]);
    if (restart)
    begin
      // Defaults restored; only the cause survives
      st_next.top_flags = pif_pkg::FLAGS_RESET;
      st_next.step_flags = pif_pkg::FLAGS_RESET;
      st_next.lin_flags = pif_pkg::FLAGS_RESET;
      st_next.reset_flag = 1'b1;
    end
    st_next.defaults_reload = restart;
    st_next.enable_refused = st_next.top_flags[pif_pkg::TSD_BIT];
    st_next.general_outputs_low = st_next.top_flags[pif_pkg::TSD_BIT] |
      ev.input_overvoltage_live;
    // Supply level, not only its edge, keeps regulators off for the whole dip
    st_next.regulators_off = st_next.general_outputs_low | restart |
      ev.analog_supply_under;
    top_view = st_reg.top_flags;
    top_view[pif_pkg::LIN_SUM_BIT] = |st_reg.lin_flags;
    top_view[pif_pkg::STEP_SUM_BIT] = |st_reg.step_flags;
    // Registered read data costs a cycle of latency but never glitches
    st_next.rdata = st_reg.rdata;
    if (req.rd)
    begin
      case (req.addr)
        pif_pkg::TOP_ADDR: st_next.rdata = top_view;
        pif_pkg::RESET_EV_ADDR: st_next.rdata = {7'h00, st_reg.reset_flag};
        pif_pkg::STEP_ADDR: st_next.rdata = st_reg.step_flags;
        pif_pkg::LIN_ADDR: st_next.rdata = st_reg.lin_flags;
        default: st_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign rdata = st_reg.rdata;
  assign regulators_off = st_reg.regulators_off;
  assign general_outputs_low = st_reg.general_outputs_low;
  assign enable_refused = st_reg.enable_refused;
  assign defaults_reload = st_reg.defaults_reload;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Event checks skip host writes and restarts, which may legally override a set
  logic quiet;
  logic supply_edge;
  assign quiet = !req.wr && !(ev.analog_supply_under && !ev_prev.analog_supply_under);
  assign supply_edge = ev.analog_supply_under && !ev_prev.analog_supply_under;

  AST_PG_DROP: assert property (
    ev_prev.power_good_active && !ev.power_good_active && quiet
    |=> st_reg.top_flags[pif_pkg::PG_DROP_BIT]) else $error("pg drop not latched");
  AST_LIN_SUM: assert property (
    req.rd && req.addr == pif_pkg::TOP_ADDR
    |=> rdata[pif_pkg::LIN_SUM_BIT] == $past(|st_reg.lin_flags))
    else $error("linear summary wrong");
  AST_STEP_SUM: assert property (
    req.rd && req.addr == pif_pkg::TOP_ADDR
    |=> rdata[pif_pkg::STEP_SUM_BIT] == $past(|st_reg.step_flags))
    else $error("step summary wrong");
  AST_SYNC: assert property (
    $changed(ev.sync_clk_present) && quiet
    |=> st_reg.top_flags[pif_pkg::SYNC_BIT]) else $error("sync clock change lost");
  AST_TSD: assert property (
    ev.thermal_shutdown_live && quiet
    |=> regulators_off && general_outputs_low) else $error("shutdown not enforced");
  AST_REFUSE: assert property (
    st_reg.top_flags[pif_pkg::TSD_BIT] && quiet
    |=> enable_refused) else $error("enable not refused");
  AST_WARN: assert property (
    ev.thermal_warning_live && !ev.thermal_shutdown_live && !ev.input_overvoltage_live &&
    !ev.analog_supply_under && !st_reg.top_flags[pif_pkg::TSD_BIT] && quiet
    |=> st_reg.top_flags[pif_pkg::WARN_BIT] && !regulators_off)
    else $error("warning handling wrong");
  AST_OVP: assert property (
    ev.input_overvoltage_live && quiet
    |=> st_reg.top_flags[pif_pkg::OVP_BIT] && general_outputs_low)
    else $error("overvoltage not handled");
  AST_MEAS: assert property (
    load_current_ready && quiet
    |=> st_reg.top_flags[pif_pkg::MEAS_BIT]) else $error("measure flag lost");
  AST_SOFT: assert property (
    req.wr && req.addr == pif_pkg::RESET_CMD_ADDR && req.wdata[0]
    |=> st_reg.reset_flag && defaults_reload && st_reg.step_flags == 8'h00 ##1 !defaults_reload)
    else $error("soft reset wrong");
  AST_SHORT: assert property (
    ev.short_low[0] [*3] ##0 st_reg.sc_cnt[0] >= 16'(SHORT_CYCLES) && quiet
    |=> st_reg.step_flags[pif_pkg::SC_OFS]) else $error("short not latched");
  AST_ILIM: assert property (
    ev.ilim[1] && quiet
    |=> st_reg.step_flags[pif_pkg::REG_STRIDE + pif_pkg::ILIM_OFS])
    else $error("current limit lost");
  AST_KEEP: assert property (
    req.wr && req.addr == pif_pkg::STEP_ADDR && req.wdata[0] && ev.ilim[0]
    |=> st_reg.step_flags[0]) else $error("coincident event lost");
  AST_RSV: assert property (
    req.rd && req.addr == pif_pkg::RESET_EV_ADDR
    |=> rdata[7:1] == 7'h00) else $error("reserved bits nonzero");
  AST_ZERO_KEEP: assert property (
    req.wr && req.addr == pif_pkg::TOP_ADDR && !supply_edge
    |=> (st_reg.top_flags & $past(st_reg.top_flags & ~req.wdata))
      == $past(st_reg.top_flags & ~req.wdata)) else $error("flag lost on write of zero");
  AST_PG_CLEAR: assert property (
    req.wr && req.addr == pif_pkg::TOP_ADDR && req.wdata[pif_pkg::PG_DROP_BIT] &&
    !(ev_prev.power_good_active && !ev.power_good_active)
    |=> !st_reg.top_flags[pif_pkg::PG_DROP_BIT]) else $error("pg drop not cleared");
  AST_RESET_CLEAR: assert property (
    req.wr && req.addr == pif_pkg::RESET_EV_ADDR && req.wdata[0] && !supply_edge
    |=> !st_reg.reset_flag) else $error("reset flag not cleared");
  AST_SUPPLY_OFF: assert property (
    ev.analog_supply_under |=> regulators_off) else $error("supply dip left regulators on");

  COV_TSD: cover property (ev.thermal_shutdown_live ##2 enable_refused);
  COV_CLEAR: cover property (req.wr && req.addr == pif_pkg::TOP_ADDR && req.wdata != 8'h00);
  COV_SOFT: cover property (defaults_reload);
  COV_SHORT: cover property (st_reg.step_flags[pif_pkg::SC_OFS]);
  COV_UNDER: cover property (supply_edge);
endmodule
`default_nettype wire

/* File: shared/pif_pkg.sv */
// Purpose: constants and carriers for the power-manager event flag bank
// Assumes: 20 MHz clock, byte-wide register port from the serial engine
`default_nettype none
package pif_pkg;
  localparam logic [7:0] TOP_ADDR = 8'h19;
  localparam logic [7:0] RESET_CMD_ADDR = 8'h18;
  localparam logic [7:0] RESET_EV_ADDR = 8'h1a;
  localparam logic [7:0] STEP_ADDR = 8'h1b;
  localparam logic [7:0] LIN_ADDR = 8'h1c;
  localparam int PG_DROP_BIT = 7;
  localparam int LIN_SUM_BIT = 6;
  localparam int STEP_SUM_BIT = 5;
  localparam int SYNC_BIT = 4;
  localparam int TSD_BIT = 3;
  localparam int WARN_BIT = 2;
  localparam int OVP_BIT = 1;
  localparam int MEAS_BIT = 0;
  localparam int SOFT_RESET_BIT = 0;
  localparam int PG_OFS = 2;
  localparam int SC_OFS = 1;
  localparam int ILIM_OFS = 0;
  localparam int REG_STRIDE = 4;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAG_MASK = 8'h77;
  localparam int SHORT_TIME_US = 1000;
  localparam int CLK_MHZ = 20;
  localparam int SHORT_CYCLES = SHORT_TIME_US * CLK_MHZ;
  localparam int NREG = 4;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pif_req_t;

  // Regulators 0,1 are the step-down converters, 2,3 the linear regulators
  typedef struct packed {
    logic power_good_active;
    logic sync_clk_present;
    logic thermal_shutdown_live;
    logic thermal_warning_live;
    logic input_overvoltage_live;
    logic analog_supply_under;
    logic [NREG-1:0] pg_bad;
    logic [NREG-1:0] short_low;
    logic [NREG-1:0] ilim;
  } pif_ev_t;
endpackage
`default_nettype wire

/* File: tb/pif_flag_bank_bench.sv */
// Purpose: self-checking bench for the event flag bank
// Assumes: shortened short-circuit count so the run stays brief
// Notes: expected read values are queued by the driver and checked by a watcher
`default_nettype none
module pif_flag_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SC = 8;
  localparam logic [7:0] T = pif_pkg::TOP_ADDR;
  localparam logic [7:0] RE = pif_pkg::RESET_EV_ADDR;
  localparam logic [7:0] ST = pif_pkg::STEP_ADDR;
  localparam logic [7:0] LN = pif_pkg::LIN_ADDR;
  localparam logic [7:0] CM = pif_pkg::RESET_CMD_ADDR;
  logic clk = 0;
  logic arst_n = 0;
  pif_pkg::pif_req_t req;
  pif_pkg::pif_ev_t ev = '0;
  logic lcr = 0;
  logic [7:0] rdata;
  logic regs_off, outs_low, refused, reload;
  logic [7:0] exp_q[$];
  logic rd_seen = 0;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_reload = 0;
  always #25 clk = ~clk;
  pif_flag_bank #(.SHORT_CYCLES(SC)) i_pif_flag_bank (.clk(clk), .arst_n(arst_n), .req(req),
    .ev_async(ev), .load_current_ready(lcr), .rdata(rdata), .regulators_off(regs_off),
    .general_outputs_low(outs_low), .enable_refused(refused), .defaults_reload(reload));
  pif_host_model i_pif_host_model (.clk(clk), .req(req));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pif_host_model.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_pif_host_model.access(1'b0, a, 8'h00);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic outs(input logic o, input logic l, input logic f);
    chk("regulators_off", {7'h00, o}, {7'h00, regs_off});
    chk("general_outputs_low", {7'h00, l}, {7'h00, outs_low});
    chk("enable_refused", {7'h00, f}, {7'h00, refused});
  endtask
  always @(posedge clk) rd_seen <= req.rd;
  always @(posedge clk) n_reload <= n_reload + (reload === 1'b1);
  always @(negedge clk)
    if (rd_seen)
      chk("rdata", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rdata);
  initial
  begin
    int sh;
    int rl;
    logic [7:0] a;
    a = 8'($urandom(32'he68e));
    cyc(4);
    arst_n = 1;
    rd(T, 8'h00);
    rd(RE, 8'h00);
    rd(ST, 8'h00);
    rd(LN, 8'h00);
    a = 8'h30 | (8'($urandom()) & 8'h0f);
    wr(a, 8'($urandom()));
    rd(a, 8'h00);
    ev.sync_clk_present = 1;
    cyc(5);
    rd(T, 8'h10);
    wr(T, 8'hef);
    rd(T, 8'h10);
    wr(T, 8'h10);
    rd(T, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      a = i < 2 ? ST : LN;
      sh = (i % 2) * pif_pkg::REG_STRIDE;
      ev.short_low[i] = 1;
      cyc(SC - 3);
      ev.short_low[i] = 0;
      ev.ilim[i] = 1;
      cyc(1 + $urandom() % 3);
      ev.ilim[i] = 0;
      ev.pg_bad[i] = 1;
      ev.short_low[i] = 1;
      cyc(SC + 6);
      ev.short_low[i] = 0;
      ev.pg_bad[i] = 0;
      rd(a, 8'h07 << sh);
      rd(T, i < 2 ? 8'h20 : 8'h40);
      wr(a, 8'h07 << sh);
      rd(a, 8'h00);
      rd(T, 8'h00);
    end
    ev.thermal_shutdown_live = 1;
    cyc(1);
    ev.thermal_shutdown_live = 0;
    cyc(4);
    outs(1, 1, 1);
    rd(T, 8'h08);
    wr(T, 8'h08);
    cyc(2);
    outs(0, 0, 0);
    ev.thermal_warning_live = 1;
    cyc(1);
    ev.thermal_warning_live = 0;
    ev.input_overvoltage_live = 1;
    cyc(5);
    outs(1, 1, 0);
    ev.input_overvoltage_live = 0;
    lcr = 1;
    cyc(1);
    lcr = 0;
    ev.power_good_active = 1;
    cyc(5);
    ev.power_good_active = 0;
    cyc(5);
    outs(0, 0, 0);
    rd(T, 8'h87);
    wr(T, 8'h86);
    rd(T, 8'h01);
    wr(T, 8'h01);
    rd(T, 8'h00);
    ev.ilim[0] = 1;
    cyc(5);
    wr(ST, 8'h01);
    rd(ST, 8'h01);
    ev.ilim[0] = 0;
    cyc(4);
    wr(ST, 8'h01);
    rd(ST, 8'h00);
    ev.sync_clk_present = 0;
    cyc(5);
    rd(T, 8'h10);
    rl = n_reload;
    wr(CM, 8'h01);
    cyc(2);
    chk("defaults_reload", 8'(rl + 1), 8'(n_reload));
    rd(T, 8'h00);
    rd(RE, 8'h01);
    rd(CM, 8'h00);
    wr(RE, 8'hfe);
    rd(RE, 8'h01);
    wr(RE, 8'h01);
    rd(RE, 8'h00);
    ev.analog_supply_under = 1;
    cyc(5);
    chk("regulators_off", 8'h01, {7'h00, regs_off});
    ev.analog_supply_under = 0;
    rd(RE, 8'h01);
    cyc(4);
    give_verdict();
  end
  initial
  begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: tb/pif_host_model.sv */
// Purpose: host side of the register port, one byte per access
// Assumes: strobes sampled on the rising edge of clk
// Notes: holds each request up to its taking edge, then a gap cycle
`default_nettype none
module pif_host_model (
  input wire logic clk,
  output var pif_pkg::pif_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #2 req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    #2 req = '0;
  endtask
endmodule
`default_nettype wire
